// File: logic/fcb_cfg.svh
// Register indices, field positions and reset values of the coefficient bank
`ifndef FCB_CFG_SVH
`define FCB_CFG_SVH

// Word indices; the APB byte address is four times the index
`define FCB_IDX_A_TAP8  14'h0427
`define FCB_IDX_A_TAP9  14'h0429
`define FCB_IDX_B_TAP1  14'h0448
`define FCB_IDX_B_TAP2  14'h044A
`define FCB_IDX_B_TAP3  14'h044C
`define FCB_IDX_STATUS  14'h0460

// Field layout of one coefficient register
`define FCB_COEF_MSB    11
`define FCB_RSVD_MSB    15
`define FCB_RSVD_LSB    12
`define FCB_REG_RESET   16'h0000
`define FCB_STAT_DUAL   0

`endif

// File: logic/fcb_pkg.sv
// Types shared by the coefficient bank
package fcb_pkg;
    typedef logic signed [11:0] fcb_coef_t;
    typedef logic [15:0]        fcb_reg_t;
    typedef logic [31:0]        fcb_word_t;
endpackage

// File: logic/fcb_coef_reg.sv
// One 16-bit coefficient register with two byte lanes
`timescale 1ns/1ps
`default_nettype none
`include "fcb_cfg.svh"

module fcb_coef_reg (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              wr_en,
    input  wire logic [1:0]        wstrb,
    input  wire fcb_pkg::fcb_reg_t wdata,
    output var  fcb_pkg::fcb_reg_t value
);
    import fcb_pkg::*;

    fcb_reg_t next_value;

    // Byte lanes merge; reserved nibble stores like any other bit
    always_comb begin
        next_value = value;
        if (wr_en && wstrb[0]) begin
            next_value[7:0] = wdata[7:0];
        end
        if (wr_en && wstrb[1]) begin
            next_value[15:8] = wdata[15:8];
        end
    end

    // Zero after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= `FCB_REG_RESET;
        end else begin
            value <= next_value;
        end
    end
endmodule

`default_nettype wire

// File: logic/fcb_bank.sv
// APB coefficient bank for the equalizer_fir taps A8, A9, B1, B2, B3
//
// Behaviour
// - Each register holds a 12-bit signed coefficient in its low field.
// - Readback returns the coefficient field's most significant bit as zero.
// - Channel A eighth-tap register drives tap eight, dual or single mode.
// - Channel A ninth-tap register drives the last tap in both modes.
// - Channel B first-tap register drives tap one, dual mode only.
// - Channel B second-tap register drives tap two in dual mode.
// - Channel B third-tap register drives tap three in dual mode.
// - Upper four bits are plain storage, reset zero, no filter effect.
// - Every coefficient register resets to zero.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "fcb_cfg.svh"

module fcb_bank (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [15:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output var fcb_pkg::fcb_word_t prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          dual_mode,
    output var fcb_pkg::fcb_coef_t chan_a_tap8_coef,
    output var fcb_pkg::fcb_coef_t chan_a_tap9_coef,
    output var fcb_pkg::fcb_coef_t chan_b_tap1_coef,
    output var fcb_pkg::fcb_coef_t chan_b_tap2_coef,
    output var fcb_pkg::fcb_coef_t chan_b_tap3_coef
);
    import fcb_pkg::*;

    localparam int NREG = 5;
    localparam logic [13:0] REG_IDX [NREG] = '{
        `FCB_IDX_A_TAP8, `FCB_IDX_A_TAP9,
        `FCB_IDX_B_TAP1, `FCB_IDX_B_TAP2, `FCB_IDX_B_TAP3
    };

    fcb_reg_t        coef_q [NREG];
    logic [NREG-1:0] hit;
    logic [NREG-1:0] wr_en;
    logic            stat_hit;
    logic            setup;
    logic            wr_take;
    fcb_word_t       next_prdata;
    logic            next_pready;
    logic            next_pslverr;
    fcb_coef_t       next_a8;
    fcb_coef_t       next_a9;
    fcb_coef_t       next_b1;
    fcb_coef_t       next_b2;
    fcb_coef_t       next_b3;

    // Address decode on word index; byte offset bits are ignored
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            hit[i] = (paddr[15:2] == REG_IDX[i]);
        end
        stat_hit = (paddr[15:2] == `FCB_IDX_STATUS);
    end

    // Writes land only at the completing access edge
    assign setup   = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite;
    assign wr_en   = hit & {NREG{wr_take}};

    // Storage: 16 bits each, zero at reset
    for (genvar g = 0; g < NREG; g++) begin : g_coef
        fcb_coef_reg u_reg (
            .pclk    (pclk),
            .presetn (presetn),
            .wr_en   (wr_en[g]),
            .wstrb   (pstrb[1:0]),
            .wdata   (pwdata[15:0]),
            .value   (coef_q[g])
        );
    end

    // Answer is prepared in setup so the access phase sees pready at once
    always_comb begin
        next_pready  = setup;
        next_pslverr = setup && !(|hit || stat_hit);
        next_prdata  = '0;
        if (setup && !pwrite) begin
            for (int i = 0; i < NREG; i++) begin
                if (hit[i]) begin
                    // Coefficient MSB reads back as zero
                    next_prdata = {16'h0000,
                                   coef_q[i][`FCB_RSVD_MSB:`FCB_RSVD_LSB],
                                   1'b0,
                                   coef_q[i][`FCB_COEF_MSB-1:0]};
                end
            end
            if (stat_hit) begin
                next_prdata[`FCB_STAT_DUAL] = dual_mode;
            end
        end
    end

    // Bus answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Tap feeds; reserved nibble never reaches the filter
    always_comb begin
        next_a8 = fcb_coef_t'(coef_q[0][`FCB_COEF_MSB:0]);
        next_a9 = fcb_coef_t'(coef_q[1][`FCB_COEF_MSB:0]);
        // Channel B filter idles in single mode, so its taps are held at zero
        next_b1 = dual_mode ? fcb_coef_t'(coef_q[2][`FCB_COEF_MSB:0]) : '0;
        next_b2 = dual_mode ? fcb_coef_t'(coef_q[3][`FCB_COEF_MSB:0]) : '0;
        next_b3 = dual_mode ? fcb_coef_t'(coef_q[4][`FCB_COEF_MSB:0]) : '0;
    end

    // Registered so every tap output comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_a_tap8_coef <= '0;
            chan_a_tap9_coef <= '0;
            chan_b_tap1_coef <= '0;
            chan_b_tap2_coef <= '0;
            chan_b_tap3_coef <= '0;
        end else begin
            chan_a_tap8_coef <= next_a8;
            chan_a_tap9_coef <= next_a9;
            chan_b_tap1_coef <= next_b1;
            chan_b_tap2_coef <= next_b2;
            chan_b_tap3_coef <= next_b3;
        end
    end
endmodule

`default_nettype wire

// File: verification/fcb_bank_checker.sv
// Port assertions for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module fcb_bank_checker (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [15:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [3:0]         pstrb,
    input wire fcb_pkg::fcb_word_t prdata,
    input wire logic               pready,
    input wire logic               dual_mode,
    input wire fcb_pkg::fcb_coef_t chan_a_tap8_coef,
    input wire fcb_pkg::fcb_coef_t chan_a_tap9_coef,
    input wire fcb_pkg::fcb_coef_t chan_b_tap1_coef,
    input wire fcb_pkg::fcb_coef_t chan_b_tap2_coef,
    input wire fcb_pkg::fcb_coef_t chan_b_tap3_coef
);
    import fcb_pkg::*;
    // Full low-half write and its word index
    wire       wr = psel && penable && pready && pwrite && pstrb[1:0] == 2'h3;
    wire [13:0] ix = paddr[15:2];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_rd_msb:
        assert property (pready && !pwrite |-> !prdata[11]) else $error("bit 11 read high");
    chk_a8_tap:
        assert property (wr && ix == 14'h0427 |=> ##1 chan_a_tap8_coef == $past(pwdata[11:0], 2))
        else $error("a tap8 wrong");
    chk_a9_tap:
        assert property (wr && ix == 14'h0429 |=> ##1 chan_a_tap9_coef == $past(pwdata[11:0], 2))
        else $error("a tap9 wrong");
    chk_b1_tap:
        assert property (wr && ix == 14'h0448 && dual_mode ##1 dual_mode
            |=> chan_b_tap1_coef == $past(pwdata[11:0], 2)) else $error("b tap1 wrong");
    chk_b1_off:
        assert property (!dual_mode |=> chan_b_tap1_coef == 12'h000) else $error("b tap1 live");
    chk_b2_off:
        assert property (!dual_mode [*2] |-> chan_b_tap2_coef == 12'h000)
        else $error("b tap2 live");
    chk_b3_off:
        assert property (!dual_mode ##1 !dual_mode |-> chan_b_tap3_coef == 12'h000)
        else $error("b3");
    chk_reset_zero:
        assert property ($rose(presetn) |->
            chan_a_tap8_coef == 12'h000 && chan_b_tap3_coef == 12'h000)
        else $error("tap not zero after reset");
endmodule
`default_nettype wire

// File: verification/fcb_bank_tb.sv
// Self-checking bench for the coefficient bank
`timescale 1ns/1ps
`default_nettype none
module fcb_bank_tb;
    import fcb_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dual_mode = 1, pready, pslverr;
    logic [15:0] paddr = '0;
    logic [31:0] pwdata = '0, rd, d;
    logic [3:0]  pstrb = 4'hF;
    logic        err;
    fcb_word_t   prdata;
    fcb_coef_t   tp [5];
    logic [13:0] ix [5] = '{14'h0427, 14'h0429, 14'h0448, 14'h044A, 14'h044C};
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    always #2 pclk = ~pclk;
    fcb_bank uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .dual_mode, .chan_a_tap8_coef(tp[0]), .chan_a_tap9_coef(tp[1]),
        .chan_b_tap1_coef(tp[2]), .chan_b_tap2_coef(tp[3]), .chan_b_tap3_coef(tp[4]));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready
    task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] dw);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'h0, dw};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the global timeout ends a hung wait
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic give_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Reset values, then write all taps with bit 11 and the top two reserved bits set
    task automatic t_regs;
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ix[i], '0);
            check(rd, 32'h0);
            apb(1'b1, ix[i], 32'hFFFF_C9A0 + 32'(i));
        end
        repeat (2) @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            d = 32'hFFFF_C9A0 + 32'(i);
            apb(1'b0, ix[i], '0);
            check(rd, {16'h0, d[15:12], 1'b0, d[10:0]});
            check(tp[i], {{20{d[11]}}, d[11:0]});
        end
        $display("regs test done");
    endtask
    // Single-channel mode silences channel B only
    task automatic t_single;
        @(posedge pclk);
        dual_mode <= 1'b0;
        repeat (3) @(posedge pclk);
        check(tp[2], 32'h0);
        check(tp[4], 32'h0);
        check(tp[0], 32'hFFFF_F9A0);
        check(tp[1], 32'hFFFF_F9A1);
        dual_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        check(tp[3], 32'hFFFF_F9A3);
        $display("single test done");
    endtask
    // Unmapped index, status word, one byte lane, reset in mid-run
    task automatic t_misc;
        apb(1'b0, 14'h0461, '0);
        check(32'(err), 32'h1);
        apb(1'b0, 14'h0460, '0);
        check(32'(err), 32'h0);
        check(rd, 32'h1);
        pstrb <= 4'h1;
        apb(1'b1, ix[2], 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, ix[2], '0);
        check(rd, 32'h0000_C100);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        check(tp[0], 32'h0);
        apb(1'b0, ix[4], '0);
        check(rd, 32'h0);
        $display("misc test done");
    endtask
    // Cut a hang short
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_single;
        t_misc;
        give_verdict;
    end
endmodule
bind fcb_bank fcb_bank_checker chk (.*);
`default_nettype wire
